// File: rtl/eepwp_defs.vh
`ifndef EEPWP_DEFS_VH
`define EEPWP_DEFS_VH

// =============================================
// clock and timing
`define EEPWP_CLK_NS 100
`define EEPWP_STROBE_NS 300
`define EEPWP_STROBE_CYC \
  ((`EEPWP_STROBE_NS + `EEPWP_CLK_NS - 1) / `EEPWP_CLK_NS)
`define EEPWP_GAP_NS 100
`define EEPWP_GAP_CYC ((`EEPWP_GAP_NS + `EEPWP_CLK_NS - 1) / `EEPWP_CLK_NS)
`define EEPWP_BYTE_WIN_NS 30000
`define EEPWP_BYTE_WIN_CYC (`EEPWP_BYTE_WIN_NS / `EEPWP_CLK_NS)
`define EEPWP_AUTO_NS 100000
`define EEPWP_AUTO_CYC (`EEPWP_AUTO_NS / `EEPWP_CLK_NS)
`define EEPWP_HOLD_MS 10
`define EEPWP_HOLD_CYC (`EEPWP_HOLD_MS * 1000000 / `EEPWP_CLK_NS)
`define EEPWP_RP_US 100
`define EEPWP_RP_CYC (`EEPWP_RP_US * 1000 / `EEPWP_CLK_NS)

// =============================================
// command sequence addresses and data
`define EEPWP_ADDR_A 17'h05555
`define EEPWP_ADDR_B 17'h02AAA
`define EEPWP_DAT_AA 8'hAA
`define EEPWP_DAT_55 8'h55
`define EEPWP_DAT_A0 8'hA0
`define EEPWP_DAT_80 8'h80
`define EEPWP_DAT_20 8'h20

// =============================================
// operation codes
`define EEPWP_OP_WRITE 2'h0
`define EEPWP_OP_READ 2'h1
`define EEPWP_OP_UNLOCK 2'h2

`endif

// File: rtl/eepwp_sync.v
`timescale 1ns/10ps
`default_nettype none

// =============================================
// three-stage synchroniser, change when stages 2 and 3 agree
module eepwp_sync (
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire din,
  output reg dout_reg
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      dout_reg <= 1'b1;
    end else if (clk_en) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout_reg <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/eepwp_host.v
// How it works
// - host holds protect high through accesses
// - host strobes are wide, glitch free
// - protect held low during host reset
// - protect high 10 ms after ready/busy returns high
// - three-byte prefix precedes each protected write
// - six-byte cancel sequence unprotects device
// - bytes within 30 us, then 100 us idle
`timescale 1ns/10ps
`default_nettype none
`include "eepwp_defs.vh"

module eepwp_host (
  // clock, reset, enable
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  // user command
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire cmd_protect,
  input wire [16:0] cmd_addr,
  input wire [7:0] cmd_data,
  output reg cmd_ready_reg,
  output reg done_reg,
  output reg [7:0] rd_data_reg,
  output reg aborted_reg,
  // device pins
  output reg [16:0] mem_addr_reg,
  output reg mem_ce_n_reg,
  output reg mem_oe_n_reg,
  output reg mem_we_n_reg,
  output reg [7:0] mem_dq_o_reg,
  output reg mem_dq_oe_reg,
  input wire [7:0] mem_dq_i,
  input wire mem_ready_busy_n,
  output reg hw_protect_n_reg
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_SETUP = 6'h02;
  localparam [5:0] ST_STROBE = 6'h04;
  localparam [5:0] ST_GAP = 6'h08;
  localparam [5:0] ST_POLL = 6'h10;
  localparam [5:0] ST_HOLD = 6'h20;
  // setup count reloaded after a write, cut to counter width
  localparam integer RP_INT = `EEPWP_RP_CYC;

  reg [5:0] state_reg;
  reg [2:0] step_reg;
  reg [2:0] nsteps_reg;
  reg [1:0] op_reg;
  reg [16:0] addr_reg;
  reg [7:0] data_reg;
  reg [19:0] cnt_reg;
  wire rb_sync;
  wire [7:0] dq_sync;
  reg [16:0] seq_addr;
  reg [7:0] seq_data;

  // =============================================
  // pin synchronisers
  eepwp_sync u_rb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .din(mem_ready_busy_n),
    .dout_reg(rb_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_dq
      eepwp_sync u_dq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .din(mem_dq_i[gi]),
        .dout_reg(dq_sync[gi])
      );
    end
  endgenerate

  // =============================================
  // command sequence table
  always @* begin
    seq_addr = addr_reg;
    seq_data = data_reg;
    if (op_reg == `EEPWP_OP_UNLOCK) begin
      case (step_reg)
        3'h0: begin
          seq_addr = `EEPWP_ADDR_A;
          seq_data = `EEPWP_DAT_AA;
        end
        3'h1: begin
          seq_addr = `EEPWP_ADDR_B;
          seq_data = `EEPWP_DAT_55;
        end
        3'h2: begin
          seq_addr = `EEPWP_ADDR_A;
          seq_data = `EEPWP_DAT_80;
        end
        3'h3: begin
          seq_addr = `EEPWP_ADDR_A;
          seq_data = `EEPWP_DAT_AA;
        end
        3'h4: begin
          seq_addr = `EEPWP_ADDR_B;
          seq_data = `EEPWP_DAT_55;
        end
        default: begin
          seq_addr = `EEPWP_ADDR_A;
          seq_data = `EEPWP_DAT_20;
        end
      endcase
    end else if (op_reg == `EEPWP_OP_WRITE && step_reg != nsteps_reg) begin
      case (step_reg)
        3'h0: begin
          seq_addr = `EEPWP_ADDR_A;
          seq_data = `EEPWP_DAT_AA;
        end
        3'h1: begin
          seq_addr = `EEPWP_ADDR_B;
          seq_data = `EEPWP_DAT_55;
        end
        default: begin
          seq_addr = `EEPWP_ADDR_A;
          seq_data = `EEPWP_DAT_A0;
        end
      endcase
    end
  end

  // =============================================
  // main sequencer
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      step_reg <= 3'h0;
      nsteps_reg <= 3'h0;
      op_reg <= `EEPWP_OP_WRITE;
      addr_reg <= 17'h00000;
      data_reg <= 8'h00;
      cnt_reg <= 20'h00000;
      cmd_ready_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      aborted_reg <= 1'b0;
      mem_addr_reg <= 17'h00000;
      mem_ce_n_reg <= 1'b1;
      mem_oe_n_reg <= 1'b1;
      mem_we_n_reg <= 1'b1;
      mem_dq_o_reg <= 8'h00;
      mem_dq_oe_reg <= 1'b0;
      hw_protect_n_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      aborted_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          hw_protect_n_reg <= 1'b1;
          mem_ce_n_reg <= 1'b1;
          mem_oe_n_reg <= 1'b1;
          mem_we_n_reg <= 1'b1;
          mem_dq_oe_reg <= 1'b0;
          if (!hw_protect_n_reg) begin
            cmd_ready_reg <= 1'b0;
            cnt_reg <= 20'h00000;
          end else if (cnt_reg < `EEPWP_RP_CYC) begin
            cnt_reg <= cnt_reg + 20'h00001;
          end else if (cmd_valid && cmd_ready_reg) begin
            cmd_ready_reg <= 1'b0;
            op_reg <= cmd_op;
            addr_reg <= cmd_addr;
            data_reg <= cmd_data;
            step_reg <= 3'h0;
            if (cmd_op == `EEPWP_OP_UNLOCK) begin
              nsteps_reg <= 3'h5;
            end else if (cmd_op == `EEPWP_OP_WRITE && cmd_protect) begin
              nsteps_reg <= 3'h3;
            end else begin
              nsteps_reg <= 3'h0;
            end
            cnt_reg <= 20'h00000;
            state_reg <= ST_SETUP;
          end else begin
            cmd_ready_reg <= 1'b1;
          end
        end
        ST_SETUP: begin
          mem_addr_reg <= seq_addr;
          mem_dq_o_reg <= seq_data;
          mem_ce_n_reg <= 1'b0;
          cnt_reg <= 20'h00000;
          if (op_reg == `EEPWP_OP_READ) begin
            mem_oe_n_reg <= 1'b0;
            mem_dq_oe_reg <= 1'b0;
          end else begin
            mem_we_n_reg <= 1'b0;
            mem_dq_oe_reg <= 1'b1;
          end
          state_reg <= ST_STROBE;
        end
        ST_STROBE: begin
          cnt_reg <= cnt_reg + 20'h00001;
          if (cnt_reg == `EEPWP_STROBE_CYC + 2) begin
            if (op_reg == `EEPWP_OP_READ) begin
              rd_data_reg <= dq_sync;
            end
            mem_we_n_reg <= 1'b1;
            mem_oe_n_reg <= 1'b1;
            mem_ce_n_reg <= 1'b1;
            cnt_reg <= 20'h00000;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          cnt_reg <= cnt_reg + 20'h00001;
          if (cnt_reg == `EEPWP_GAP_CYC) begin
            mem_dq_oe_reg <= 1'b0;
            cnt_reg <= 20'h00000;
            if (op_reg == `EEPWP_OP_READ) begin
              done_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else if (step_reg != nsteps_reg) begin
              step_reg <= step_reg + 3'h1;
              state_reg <= ST_SETUP;
            end else begin
              state_reg <= ST_POLL;
            end
          end
        end
        ST_POLL: begin
          // wait out auto-start idle, then ready/busy high
          cnt_reg <= cnt_reg + 20'h00001;
          if (cnt_reg >= `EEPWP_AUTO_CYC && rb_sync) begin
            cnt_reg <= 20'h00000;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_reg <= cnt_reg + 20'h00001;
          if (cnt_reg >= `EEPWP_HOLD_CYC) begin
            done_reg <= 1'b1;
            cnt_reg <= RP_INT[19:0];
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          aborted_reg <= 1'b1;
          hw_protect_n_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: test/eepwp_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// host pin checker
module eepwp_host_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // device pins
  input wire logic [16:0] mem_addr_reg,
  input wire logic mem_ce_n_reg,
  input wire logic mem_oe_n_reg,
  input wire logic mem_we_n_reg,
  input wire logic [7:0] mem_dq_o_reg,
  input wire logic mem_dq_oe_reg,
  input wire logic hw_protect_n_reg,
  // user side
  input wire logic cmd_ready_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_we_low;
    !mem_we_n_reg[*3];
  endsequence
  sequence s_a0_end;
    $rose(mem_we_n_reg) && mem_addr_reg == 17'h05555 && mem_dq_o_reg == 8'hA0;
  endsequence
  chk_prot_reset: assert property ($fell(sys_rst) |-> !hw_protect_n_reg)
    else $error("protect high at reset release");
  chk_prot_steady: assert property (!$fell(hw_protect_n_reg))
    else $error("protect dropped outside reset");
  chk_strobe_prot: assert property (!mem_ce_n_reg |-> hw_protect_n_reg)
    else $error("select while protected");
  chk_strobe_wide: assert property ($fell(mem_we_n_reg) |-> s_we_low)
    else $error("write strobe too short");
  chk_data_hold: assert property (
    $rose(mem_we_n_reg) |-> mem_dq_oe_reg && $stable(mem_dq_o_reg))
    else $error("data not held at strobe end");
  chk_addr_hold: assert property (
    !mem_we_n_reg && !$past(mem_we_n_reg) |-> $stable(mem_addr_reg))
    else $error("address moved in strobe");
  chk_no_clash: assert property (
    !mem_oe_n_reg |-> !mem_dq_oe_reg && mem_we_n_reg)
    else $error("bus clash on read");
  chk_idle_quiet: assert property (
    cmd_ready_reg |-> mem_ce_n_reg && mem_we_n_reg)
    else $error("strobe active in idle");
  chk_prefix_data: assert property (
    s_a0_end |-> ##[1:299] $fell(mem_we_n_reg))
    else $error("no data after prefix");
  chk_enable_freeze: assert property (
    !clk_en |=> $stable(mem_we_n_reg) && $stable(mem_ce_n_reg) &&
    $stable(hw_protect_n_reg) && $stable(cmd_ready_reg))
    else $error("state moved while disabled");
endmodule

bind eepwp_host eepwp_host_asserts u_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .mem_addr_reg(mem_addr_reg),
  .mem_ce_n_reg(mem_ce_n_reg),
  .mem_oe_n_reg(mem_oe_n_reg),
  .mem_we_n_reg(mem_we_n_reg),
  .mem_dq_o_reg(mem_dq_o_reg),
  .mem_dq_oe_reg(mem_dq_oe_reg),
  .hw_protect_n_reg(hw_protect_n_reg),
  .cmd_ready_reg(cmd_ready_reg)
);
`default_nettype wire

// File: test/eepwp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// device model
module eepwp_dev_model #(parameter int WR_NS = 20000) (
  // host pins
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] din,
  input wire logic hw_protect_n,
  // device outputs
  output logic [7:0] dout,
  output logic rb_n
);
  logic [7:0] mem [int];
  logic [7:0] pg [int];
  logic [16:0] a_lat;
  logic [7:0] last = 8'h00;
  bit prot, armed, c80, alive;
  time t_fall, t_last;
  wire logic st = ce_n | we_n;
  initial rb_n = 1'b1;
  always @(negedge st) begin
    a_lat = addr;
    t_fall = $time;
  end
  always @(posedge st) begin
    if (hw_protect_n && $time - t_fall > 20) begin
      t_last = $time;
      last = din;
      if (rb_n) alive = 1;
      rb_n = 1'b0;
      if (a_lat == 17'h05555 && din == 8'hA0)
        {prot, armed} = 2'b11;
      else if (a_lat == 17'h05555 && din == 8'h80) c80 = 1;
      else if (a_lat == 17'h05555 && din == 8'h20 && c80)
        {prot, c80} = 2'b00;
      else if (din == 8'hAA && a_lat == 17'h05555) ;
      else if (din == 8'h55 && a_lat == 17'h02AAA) ;
      else if (!prot || armed) pg[a_lat] = din;
    end
  end
  always @(negedge hw_protect_n) alive = 0;
  always begin
    #1000;
    if (!rb_n && $time - t_last >= 100000) begin
      #(WR_NS);
      if (alive) foreach (pg[k]) mem[k] = pg[k];
      pg.delete();
      armed = 0;
      rb_n = 1'b1;
    end
  end
  always @* begin
    if (!ce_n && !oe_n && hw_protect_n)
      dout = !rb_n ? {~last[7], 7'h00}
        : mem.exists(addr) ? mem[addr] : 8'hFF;
    else
      dout = ~last;
  end
endmodule
`default_nettype wire

// File: test/eepwp_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// host bench
module eepwp_host_tb;
  logic ref_clk = 0, sys_rst = 1, clk_en = 1, cmd_valid = 0, cmd_protect = 0;
  logic [1:0] cmd_op = 0;
  logic [16:0] cmd_addr = 0, mem_addr_reg;
  logic [7:0] cmd_data = 0, rd_data_reg, mem_dq_o_reg, dev_dq, mem_dq_i;
  logic cmd_ready_reg, done_reg, aborted_reg, mem_ce_n_reg, mem_oe_n_reg;
  logic mem_we_n_reg, mem_dq_oe_reg, rb_n, hw_protect_n_reg;
  int mismatches = 0, comparisons = 0;
  always #50 ref_clk = ~ref_clk;
  assign mem_dq_i = mem_dq_oe_reg ? mem_dq_o_reg : dev_dq;
  eepwp_host dut (.ref_clk, .sys_rst, .clk_en, .cmd_valid, .cmd_op,
    .cmd_protect, .cmd_addr, .cmd_data, .cmd_ready_reg, .done_reg,
    .rd_data_reg, .aborted_reg, .mem_addr_reg, .mem_ce_n_reg,
    .mem_oe_n_reg, .mem_we_n_reg, .mem_dq_o_reg, .mem_dq_oe_reg, .mem_dq_i,
    .mem_ready_busy_n(rb_n), .hw_protect_n_reg);
  eepwp_dev_model dev (.addr(mem_addr_reg), .ce_n(mem_ce_n_reg),
    .oe_n(mem_oe_n_reg), .we_n(mem_we_n_reg), .din(mem_dq_o_reg),
    .hw_protect_n(hw_protect_n_reg), .dout(dev_dq), .rb_n);
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task run(input [1:0] op, input p, input [16:0] a, input [7:0] d);
    int n;
    logic ab;
    n = 0;
    ab = 1'b0;
    while (cmd_ready_reg !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      report_and_stop;
    end
    n = 0;
    {cmd_op, cmd_protect, cmd_addr, cmd_data} <= {op, p, a, d};
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (done_reg !== 1'b1 && n < 250000) begin
      @(posedge ref_clk);
      if (aborted_reg !== 1'b0) ab = 1'b1;
      n++;
    end
    if (n >= 250000) begin
      mismatches++;
      report_and_stop;
    end
    check({7'h00, ab}, 8'h00, "abort flag");
  endtask
  task t_freeze;
    int n;
    n = 0;
    while (cmd_ready_reg !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      report_and_stop;
    end
    n = 0;
    {cmd_op, cmd_protect} <= {2'h1, 1'b0};
    {cmd_addr, cmd_data} <= {17'h01234, 8'h00};
    cmd_valid <= 1'b1;
    clk_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check({7'h00, cmd_ready_reg}, 8'h01, "frozen ready");
    check({7'h00, hw_protect_n_reg}, 8'h01, "frozen protect");
    clk_en <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (done_reg !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      report_and_stop;
    end
    check(rd_data_reg, 8'h3C, "read after freeze");
    $display("test freeze done");
  endtask
  task t_read_blank;
    run(2'h1, 0, 17'h00010, 8'h00);
    check(rd_data_reg, 8'hFF, "blank read");
    $display("test read_blank done");
  endtask
  task t_prot_write;
    run(2'h0, 1, 17'h01234, 8'h3C);
    check({7'h00, dev.prot}, 8'h01, "protect mode");
    run(2'h1, 0, 17'h01234, 8'h00);
    check(rd_data_reg, 8'h3C, "protected write");
    $display("test prot_write done");
  endtask
  task t_cancel;
    run(2'h2, 0, 17'h00000, 8'h00);
    check({7'h00, dev.prot}, 8'h00, "cancel mode");
    run(2'h1, 0, 17'h05555, 8'h00);
    check(rd_data_reg, 8'hFF, "cancel data");
    $display("test cancel done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_read_blank;
    t_prot_write;
    t_freeze;
    t_cancel;
    report_and_stop;
  end
endmodule
`default_nettype wire
